// ===== lbc_map.vh
// constants for the local bus command controller
`ifndef LBC_MAP_VH
`define LBC_MAP_VH

// ----------------------------------------------------------------
// apb register offsets
// ----------------------------------------------------------------
`define LBC_ADDR_CTRL 8'h00
`define LBC_ADDR_STAT 8'h04
`define LBC_ADDR_CYCLES 8'h08
`define LBC_ADDR_WAITS 8'h0C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LBC_CTRL_EN_BIT 0
`define LBC_CTRL_RESET 1'h1
`define LBC_STAT_STATE_LSB 0
`define LBC_STAT_PHASE_BIT 2
`define LBC_STAT_TYPE_LSB 3
`define LBC_STAT_SEL_BIT 6
`define LBC_STAT_MODE_BIT 7
`define LBC_STAT_GRANT_BIT 8

// ----------------------------------------------------------------
// bus states
// ----------------------------------------------------------------
`define LBC_ST_IDLE 2'h0
`define LBC_ST_STATUS 2'h1
`define LBC_ST_COMMAND 2'h2

// ----------------------------------------------------------------
// cycle types {memory_or_io_select, status_a_n, status_b_n}
// ----------------------------------------------------------------
`define LBC_T_INT_ACK_CMD 3'h0
`define LBC_T_IORD 3'h1
`define LBC_T_IOWR 3'h2
`define LBC_T_HALT 3'h4
`define LBC_T_MRD 3'h5
`define LBC_T_MWR 3'h6

// ----------------------------------------------------------------
// timing counts in clock cycles
// ----------------------------------------------------------------
`define LBC_RD_DELAY 2'h1
`define LBC_WR_DELAY 2'h2
`define LBC_WR_DEN_DELAY 2'h1
`define LBC_GRANT_EDGES 2'h3

`endif

// ===== lbc_controller.v
// local bus command controller with apb status and control registers
//
// Behaviour
// (RQ1) idle, status and command states each span two clock cycles (phases).
// (RQ2) stay idle as long as no bus cycle is started.
// (RQ3) sample both status inputs every cycle; either low starts a cycle.
// (RQ4) the cycle after status is seen low is treated as phase two.
// (RQ5) status state is always followed by command state; waits repeat command. Code goes to idle instead for halt or cycle enable low.
// (RQ6) ready high at end of command state repeats it as a wait state.
// (RQ7) outputs hold their values during wait states.
// (RQ8) ready low ends the cycle; go to status directly if status active.
// (RQ9) decode cycle type from select and both status bits.
// (RQ10) one matching command, direction low for reads, strobes unless halt.
// (RQ11) cascade enable only in interrupt acknowledge cycles.
// (RQ12) strap high delays command and transceiver enable for shared bus.
// (RQ13) in shared mode the master must insert at least one wait state.
// (RQ14) strap low adds no delay; cycles complete with no wait states.
// (RQ15) transceiver enable drops before direction changes.
// (RQ16) all read cycles share one timing, differing only in command.
// (RQ17) both write cycles share one timing, distinct from reads.
// (RQ18) halt cycles drive no output and ignore control inputs.
// (RQ19) master runs at half clock rate and starts status in phase one.
// (RQ20) cycle enable input is latched so a decoder may drive it directly.
// (RQ21) no shared-bus command drive while grant is inactive.
// (RQ22) command delay input sets command start; ready sets its end.
// (RQ23) shared mode: read cmd +1 cycle, write cmd +2, write enable +1.
// (RQ24) address strobe high in second half of status state only.
// (RQ25) cycle enable sampled at end of status; low keeps outputs idle.
// (RQ26) commands go active three edges after grant; enable may follow at once.
// (RQ27) reset gives idle, commands off, strobes low, direction high.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lbc_map.vh"

module lbc_controller
(
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // local bus master status and ready
  input wire cycle_status_a_n,
  input wire cycle_status_b_n,
  input wire memory_or_io_select,
  input wire ready_n,
  // control inputs
  input wire latched_cycle_enable,
  input wire command_delay_in,
  input wire arbiter_grant_n,
  input wire async_command_enable,
  input wire timing_mode_strap,
  // command outputs, active low
  output wire int_ack_cmd_n,
  output wire io_read_cmd_n,
  output wire io_write_cmd_n,
  output wire mem_read_cmd_n,
  output wire mem_write_cmd_n,
  output wire cmd_out_en_n,
  // control outputs
  output wire addr_latch_strobe,
  output wire cascade_addr_enable,
  output wire transceiver_enable,
  output wire transfer_direction
);

  // ----------------------------------------------------------------
  // cycle type decode
  // ----------------------------------------------------------------
  function is_read;
    input [2:0] t;
    begin
      is_read = (t == `LBC_T_INT_ACK_CMD) || (t == `LBC_T_IORD) || (t == `LBC_T_MRD);
    end
  endfunction

  function is_write;
    input [2:0] t;
    begin
      is_write = (t == `LBC_T_IOWR) || (t == `LBC_T_MWR);
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [8:0] sync1_ff;
  reg [8:0] sync2_ff;
  wire sa_s = sync2_ff[0];
  wire sb_s = sync2_ff[1];
  wire mio_s = sync2_ff[2];
  wire rdy_n_s = sync2_ff[3];
  wire latched_cycle_enable_s = sync2_ff[4];
  wire command_delay_in_s = sync2_ff[5];
  wire aen_n_s = sync2_ff[6];
  wire cen_s = sync2_ff[7];
  wire mb_s = sync2_ff[8];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= 9'h0FF;
      sync2_ff <= 9'h0FF;
    end
    else
    begin
      sync1_ff <= {timing_mode_strap, async_command_enable, arbiter_grant_n,
                   command_delay_in, latched_cycle_enable, ready_n,
                   memory_or_io_select, cycle_status_b_n, cycle_status_a_n};
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  reg [1:0] st_ff, cnt_ff, grant_ff;
  reg ph_ff, sel_ff, cmd_on_ff, ctrl_en_ff;
  reg [2:0] type_ff;
  reg [31:0] cycles_ff, waits_ff;
  reg int_ack_cmd_n_ff, iord_n_ff, iowr_n_ff, mrd_n_ff, mwr_n_ff, oe_n_ff;
  reg ale_ff, mce_ff, den_ff, dtr_ff;

  reg [1:0] nxt_st, nxt_cnt, nxt_grant;
  reg nxt_ph, nxt_sel, nxt_cmd_on, nxt_done, nxt_wait;
  reg [2:0] nxt_type;
  reg nxt_int_ack_cmd_n, nxt_iord_n, nxt_iowr_n, nxt_mrd_n, nxt_mwr_n, nxt_oe_n;
  reg nxt_ale, nxt_mce, nxt_den, nxt_dtr;

  reg start, active, gate, fire, want_den, want_dtr;
  reg [1:0] dly;

  // ----------------------------------------------------------------
  // bus state sequencer and outputs
  // ----------------------------------------------------------------
  always @*
  begin
    start = ctrl_en_ff & ~(sa_s & sb_s); // see (RQ3)
    nxt_st = st_ff;
    nxt_ph = ~ph_ff; // see (RQ1)
    nxt_type = type_ff;
    nxt_sel = sel_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_wait = 1'b0;
    case (st_ff)
      `LBC_ST_IDLE:
      begin
        if (start)
        begin
          nxt_st = `LBC_ST_STATUS;
          nxt_ph = 1'b1; // see (RQ4)
          nxt_type = {mio_s, sa_s, sb_s}; // see (RQ9)
        end
        else
          nxt_st = `LBC_ST_IDLE; // see (RQ2)
      end
      `LBC_ST_STATUS:
      begin
        nxt_sel = latched_cycle_enable_s; // see (RQ20) (RQ25)
        nxt_cnt = 2'h0;
        nxt_ph = 1'b0;
        if (type_ff == `LBC_T_HALT || !latched_cycle_enable_s)
          nxt_st = `LBC_ST_IDLE; // see (RQ18) (RQ25)
        else
          nxt_st = `LBC_ST_COMMAND; // see (RQ5)
      end
      `LBC_ST_COMMAND:
      begin
        if (cnt_ff != 2'h3)
          nxt_cnt = cnt_ff + 2'h1;
        if (ph_ff && !rdy_n_s) // see (RQ6) (RQ8)
        begin
          nxt_done = 1'b1;
          if (start)
          begin
            nxt_st = `LBC_ST_STATUS;
            nxt_ph = 1'b1;
            nxt_type = {mio_s, sa_s, sb_s};
          end
          else
          begin
            nxt_st = `LBC_ST_IDLE;
            nxt_ph = 1'b0;
          end
        end
        else if (ph_ff)
          nxt_wait = 1'b1; // see (RQ6)
      end
      default:
      begin
        nxt_st = `LBC_ST_IDLE;
        nxt_ph = 1'b0;
      end
    endcase

    // grant age, saturating
    if (aen_n_s)
      nxt_grant = 2'h0;
    else if (grant_ff != `LBC_GRANT_EDGES)
      nxt_grant = grant_ff + 2'h1;
    else
      nxt_grant = grant_ff;

    // command start, delayed by mode and delay input
    active = (nxt_st == `LBC_ST_COMMAND) & nxt_sel;
    if (mb_s && is_read(nxt_type))
      dly = `LBC_RD_DELAY; // see (RQ23) (RQ16)
    else if (mb_s)
      dly = `LBC_WR_DELAY; // see (RQ23) (RQ17)
    else
      dly = 2'h0; // see (RQ14)
    nxt_cmd_on = active & ((cmd_on_ff & (st_ff == `LBC_ST_COMMAND))
                 | ((nxt_cnt >= dly) & ~command_delay_in_s)); // see (RQ22) (RQ7)
    if (mb_s)
      gate = (nxt_grant == `LBC_GRANT_EDGES); // see (RQ26) (RQ21)
    else
      gate = cen_s;
    fire = nxt_cmd_on & gate; // see (RQ12)
    nxt_int_ack_cmd_n = ~(fire & (nxt_type == `LBC_T_INT_ACK_CMD)); // see (RQ10)
    nxt_iord_n = ~(fire & (nxt_type == `LBC_T_IORD));
    nxt_iowr_n = ~(fire & (nxt_type == `LBC_T_IOWR));
    nxt_mrd_n = ~(fire & (nxt_type == `LBC_T_MRD));
    nxt_mwr_n = ~(fire & (nxt_type == `LBC_T_MWR));
    nxt_oe_n = mb_s & aen_n_s; // see (RQ21)

    // strobes
    nxt_ale = (nxt_st == `LBC_ST_STATUS) & (nxt_type != `LBC_T_HALT); // see (RQ24)
    nxt_mce = (nxt_type == `LBC_T_INT_ACK_CMD) & ((nxt_st == `LBC_ST_STATUS)
              | ((nxt_st == `LBC_ST_COMMAND) & (nxt_cnt == 2'h0))); // see (RQ11)

    // direction and transceiver enable
    want_dtr = ~(is_read(nxt_type) & (active | (nxt_st == `LBC_ST_STATUS) & latched_cycle_enable_s)); // see (RQ10)
    if (den_ff && (want_dtr != dtr_ff))
      nxt_dtr = dtr_ff; // see (RQ15)
    else
      nxt_dtr = want_dtr;
    if (is_read(nxt_type))
      want_den = active;
    else if (is_write(nxt_type) && mb_s)
      want_den = active & (nxt_cnt >= `LBC_WR_DEN_DELAY); // see (RQ23)
    else if (is_write(nxt_type))
      want_den = active | (nxt_st == `LBC_ST_STATUS); // see (RQ17)
    else
      want_den = 1'b0; // see (RQ18)
    if (mb_s)
      want_den = want_den & ~aen_n_s; // see (RQ26)
    else
      want_den = want_den & cen_s;
    nxt_den = want_den & (nxt_dtr == want_dtr) & ~(den_ff & (dtr_ff != nxt_dtr)); // see (RQ15)
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= `LBC_ST_IDLE; // see (RQ27)
      ph_ff <= 1'b0;
      type_ff <= 3'h7;
      sel_ff <= 1'b0;
      cnt_ff <= 2'h0;
      cmd_on_ff <= 1'b0;
      grant_ff <= 2'h0;
      int_ack_cmd_n_ff <= 1'b1;
      iord_n_ff <= 1'b1;
      iowr_n_ff <= 1'b1;
      mrd_n_ff <= 1'b1;
      mwr_n_ff <= 1'b1;
      oe_n_ff <= 1'b0;
      ale_ff <= 1'b0;
      mce_ff <= 1'b0;
      den_ff <= 1'b0;
      dtr_ff <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      type_ff <= nxt_type;
      sel_ff <= nxt_sel;
      cnt_ff <= nxt_cnt;
      cmd_on_ff <= nxt_cmd_on;
      grant_ff <= nxt_grant;
      int_ack_cmd_n_ff <= nxt_int_ack_cmd_n;
      iord_n_ff <= nxt_iord_n;
      iowr_n_ff <= nxt_iowr_n;
      mrd_n_ff <= nxt_mrd_n;
      mwr_n_ff <= nxt_mwr_n;
      oe_n_ff <= nxt_oe_n;
      ale_ff <= nxt_ale;
      mce_ff <= nxt_mce;
      den_ff <= nxt_den;
      dtr_ff <= nxt_dtr;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] prdata_ff;
  reg [31:0] nxt_rdata;
  reg nxt_err;
  wire wr_take = psel & penable & pready_ff & pwrite;
  wire wr_cycles = wr_take & (paddr == `LBC_ADDR_CYCLES);
  wire wr_waits = wr_take & (paddr == `LBC_ADDR_WAITS);

  always @*
  begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    case (paddr)
      `LBC_ADDR_CTRL:
        nxt_rdata[`LBC_CTRL_EN_BIT] = ctrl_en_ff;
      `LBC_ADDR_STAT:
      begin
        nxt_rdata[`LBC_STAT_STATE_LSB+1:`LBC_STAT_STATE_LSB] = st_ff;
        nxt_rdata[`LBC_STAT_PHASE_BIT] = ph_ff;
        nxt_rdata[`LBC_STAT_TYPE_LSB+2:`LBC_STAT_TYPE_LSB] = type_ff;
        nxt_rdata[`LBC_STAT_SEL_BIT] = sel_ff;
        nxt_rdata[`LBC_STAT_MODE_BIT] = mb_s;
        nxt_rdata[`LBC_STAT_GRANT_BIT] = ~aen_n_s;
      end
      `LBC_ADDR_CYCLES:
        nxt_rdata = cycles_ff;
      `LBC_ADDR_WAITS:
        nxt_rdata = waits_ff;
      default:
        nxt_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      ctrl_en_ff <= `LBC_CTRL_RESET;
      cycles_ff <= 32'h00000000;
      waits_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= psel & ~penable;
      if (psel && !penable)
      begin
        pslverr_ff <= nxt_err;
        prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
      end
      else
        pslverr_ff <= 1'b0;
      if (wr_take && paddr == `LBC_ADDR_CTRL)
        ctrl_en_ff <= pwdata[`LBC_CTRL_EN_BIT];
      // a count in the same cycle as a clear leaves the counter at one
      if (nxt_done)
        cycles_ff <= wr_cycles ? 32'h00000001 : cycles_ff + 32'h00000001;
      else if (wr_cycles)
        cycles_ff <= 32'h00000000;
      if (nxt_wait)
        waits_ff <= wr_waits ? 32'h00000001 : waits_ff + 32'h00000001;
      else if (wr_waits)
        waits_ff <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign int_ack_cmd_n = int_ack_cmd_n_ff;
  assign io_read_cmd_n = iord_n_ff;
  assign io_write_cmd_n = iowr_n_ff;
  assign mem_read_cmd_n = mrd_n_ff;
  assign mem_write_cmd_n = mwr_n_ff;
  assign cmd_out_en_n = oe_n_ff;
  assign addr_latch_strobe = ale_ff;
  assign cascade_addr_enable = mce_ff;
  assign transceiver_enable = den_ff;
  assign transfer_direction = dtr_ff;

endmodule

`default_nettype wire

// ===== lbc_controller_sva.sv
// concurrent checks on the local bus command controller ports
`timescale 1ns/1ps
`default_nettype none

module lbc_controller_chk
(
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // control inputs
  input wire latched_cycle_enable,
  input wire command_delay_in,
  input wire arbiter_grant_n,
  input wire async_command_enable,
  input wire timing_mode_strap,
  // outputs
  input wire int_ack_cmd_n,
  input wire io_read_cmd_n,
  input wire io_write_cmd_n,
  input wire mem_read_cmd_n,
  input wire mem_write_cmd_n,
  input wire cmd_out_en_n,
  input wire addr_latch_strobe,
  input wire cascade_addr_enable,
  input wire transceiver_enable,
  input wire transfer_direction
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_n = int_ack_cmd_n & io_read_cmd_n & mem_read_cmd_n;
  wire wr_n = io_write_cmd_n & mem_write_cmd_n;
  sequence s_fast;
    (!timing_mode_strap && async_command_enable && latched_cycle_enable && !command_delay_in)[*6];
  endsequence
  sequence s_shared;
    (timing_mode_strap && !arbiter_grant_n && latched_cycle_enable && !command_delay_in)[*8];
  endsequence
  sequence s_wr_steps;
    (wr_n && !transceiver_enable) ##1 (wr_n && transceiver_enable) ##1 !wr_n;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb answer missing");
  chk_apb_unmapped: assert property (psel && !penable && paddr > 8'h0C
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_one_cmd: assert property (
    $onehot0(~{int_ack_cmd_n, io_read_cmd_n, io_write_cmd_n, mem_read_cmd_n, mem_write_cmd_n}))
    else $error("more than one command active");
  chk_cascade_only: assert property (
    cascade_addr_enable |-> wr_n && io_read_cmd_n && mem_read_cmd_n)
    else $error("cascade enable outside int ack");
  chk_dir_guard: assert property (
    $changed(transfer_direction) |-> !transceiver_enable && !$past(transceiver_enable))
    else $error("direction changed with transceiver enabled");
  chk_ale_pulse: assert property ($rose(addr_latch_strobe) |=> !addr_latch_strobe)
    else $error("address strobe longer than half a state");
  chk_fast_read: assert property (s_fast ##0 $fell(transfer_direction) |=> !rd_n)
    else $error("undelayed read command late");
  chk_shared_read: assert property (
    s_shared ##0 $fell(transfer_direction) |=> rd_n ##1 !rd_n)
    else $error("shared read command not delayed one cycle");
  chk_shared_write: assert property (
    s_shared ##0 ($rose(addr_latch_strobe) && transfer_direction) |=> s_wr_steps)
    else $error("shared write timing wrong");
  chk_grant_off: assert property (
    (timing_mode_strap && arbiter_grant_n)[*4] |-> cmd_out_en_n)
    else $error("commands driven without grant");
  chk_cmd_span: assert property ($fell(rd_n & wr_n) |=> !(rd_n & wr_n))
    else $error("command shorter than a command state");
endmodule

bind lbc_controller lbc_controller_chk u_lbc_controller_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .latched_cycle_enable, .command_delay_in, .arbiter_grant_n,
  .async_command_enable, .timing_mode_strap, .int_ack_cmd_n, .io_read_cmd_n, .io_write_cmd_n,
  .mem_read_cmd_n, .mem_write_cmd_n, .cmd_out_en_n, .addr_latch_strobe, .cascade_addr_enable,
  .transceiver_enable, .transfer_direction);

`default_nettype wire

// ===== lbc_master_model.sv
// local bus master model driving status, select and ready
`timescale 1ns/1ps
`default_nettype none

module lbc_master_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic start,
  input wire logic [2:0] typ,
  input wire logic [1:0] waits,
  output logic busy,
  // local bus
  output logic cycle_status_a_n,
  output logic cycle_status_b_n,
  output logic memory_or_io_select,
  output logic ready_n
);
  int cnt_ff;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      cnt_ff <= 0;
      {memory_or_io_select, cycle_status_a_n, cycle_status_b_n} <= 3'h3;
      ready_n <= 1'b1;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      cnt_ff <= 0;
      {memory_or_io_select, cycle_status_a_n, cycle_status_b_n} <= typ;
      ready_n <= 1'b1;
    end
    else if (busy)
    begin
      cnt_ff <= cnt_ff + 1;
      // status held for one internal clock period of two cycles
      if (cnt_ff == 1)
      begin
        {cycle_status_a_n, cycle_status_b_n} <= 2'h3;
        memory_or_io_select <= ~memory_or_io_select;
      end
      // ready held high to ask for waits
      ready_n <= (cnt_ff + 1 < 2 * waits + 2);
      if (cnt_ff == 2 * waits + 8)
        busy <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== tb_top.sv
// self-checking testbench for the local bus command controller
`timescale 1ns/1ps
`default_nettype none
`include "lbc_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic pclk, presetn, psel, penable, pwrite, start, clr, perr;
  logic latched_cycle_enable, command_delay_in, arbiter_grant_n;
  logic async_command_enable, timing_mode_strap;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [2:0] typ;
  logic [1:0] waits;
  logic [8:0] seen;
  int errors, n_checks;
  wire [31:0] prdata;
  wire pready, pslverr, busy, cycle_status_a_n, cycle_status_b_n, memory_or_io_select, ready_n;
  wire int_ack_cmd_n, io_read_cmd_n, io_write_cmd_n, mem_read_cmd_n, mem_write_cmd_n;
  wire cmd_out_en_n, addr_latch_strobe, cascade_addr_enable, transceiver_enable;
  wire transfer_direction;

  lbc_controller u_lbc_controller (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cycle_status_a_n, .cycle_status_b_n, .memory_or_io_select,
    .ready_n, .latched_cycle_enable, .command_delay_in, .arbiter_grant_n, .async_command_enable,
    .timing_mode_strap, .int_ack_cmd_n, .io_read_cmd_n, .io_write_cmd_n, .mem_read_cmd_n,
    .mem_write_cmd_n, .cmd_out_en_n, .addr_latch_strobe, .cascade_addr_enable,
    .transceiver_enable, .transfer_direction);
  lbc_master_model u_lbc_master_model (.pclk, .presetn, .start, .typ, .waits, .busy,
    .cycle_status_a_n, .cycle_status_b_n, .memory_or_io_select, .ready_n);

  // ----------------------------------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (clr)
      seen <= 9'h000;
    else
      seen <= seen | {~mem_write_cmd_n, ~mem_read_cmd_n, ~io_write_cmd_n, ~io_read_cmd_n,
        ~int_ack_cmd_n, addr_latch_strobe, cascade_addr_enable, transceiver_enable,
        ~transfer_direction};

  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    complete_run;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task complete_run;
  begin
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  // expected {commands, strobe, cascade, transceiver, direction low}
  function automatic logic [8:0] exp_of(input logic [2:0] t, input logic on);
    logic [4:0] c;
    case (t)
      `LBC_T_INT_ACK_CMD: c = 5'h01;
      `LBC_T_IORD: c = 5'h02;
      `LBC_T_IOWR: c = 5'h04;
      `LBC_T_MRD: c = 5'h08;
      `LBC_T_MWR: c = 5'h10;
      default: c = 5'h00;
    endcase
    return {on ? c : 5'h00, c != 5'h00, t == `LBC_T_INT_ACK_CMD, on && c != 5'h00,
      on && (t == `LBC_T_INT_ACK_CMD || t == `LBC_T_IORD || t == `LBC_T_MRD)};
  endfunction

  task run(input logic [2:0] t, input logic [1:0] w, input logic [8:0] e);
  begin
    clr <= 1'b1;
    repeat (8) @(posedge pclk);
    clr <= 1'b0;
    typ <= t;
    waits <= w;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    while (busy)
      @(posedge pclk);
    repeat (4) @(posedge pclk);
    `CHK("outputs seen", e, seen)
  end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, start, command_delay_in, arbiter_grant_n} = 7'h00;
    {clr, latched_cycle_enable, async_command_enable, timing_mode_strap} = 4'hE;
    {paddr, pwdata, typ, waits} = 45'h0;
    repeat (6) @(posedge pclk);
    `CHK("reset outputs", 9'h1F1, {int_ack_cmd_n, io_read_cmd_n, io_write_cmd_n, mem_read_cmd_n,
      mem_write_cmd_n, addr_latch_strobe, cascade_addr_enable, transceiver_enable,
      transfer_direction})
    presetn <= 1'b1;
    apb(1'b0, `LBC_ADDR_CTRL, 32'h0);
    `CHK("ctrl", {31'h0, `LBC_CTRL_RESET}, rdat)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 33'h100000000, {perr, rdat})
    for (int i = 0; i < 8; i++)
      run(i[2:0], 2'h0, exp_of(i[2:0], 1'b1));
    apb(1'b1, `LBC_ADDR_CYCLES, 32'h0);
    apb(1'b1, `LBC_ADDR_WAITS, 32'h0);
    run(`LBC_T_MWR, 2'h2, exp_of(`LBC_T_MWR, 1'b1));
    apb(1'b0, `LBC_ADDR_CYCLES, 32'h0);
    `CHK("cycles", 32'h1, rdat)
    apb(1'b0, `LBC_ADDR_WAITS, 32'h0);
    `CHK("waits", 32'h2, rdat)
    latched_cycle_enable <= 1'b0;
    run(`LBC_T_MRD, 2'h0, exp_of(`LBC_T_MRD, 1'b0));
    latched_cycle_enable <= 1'b1;
    apb(1'b1, `LBC_ADDR_CTRL, 32'h0);
    run(`LBC_T_MRD, 2'h0, 9'h000);
    apb(1'b1, `LBC_ADDR_CTRL, 32'h1);
    command_delay_in <= 1'b1;
    run(`LBC_T_MRD, 2'h1, 9'h00B);
    command_delay_in <= 1'b0;
    timing_mode_strap <= 1'b1;
    run(`LBC_T_MRD, 2'h1, exp_of(`LBC_T_MRD, 1'b1));
    run(`LBC_T_IOWR, 2'h1, exp_of(`LBC_T_IOWR, 1'b1));
    arbiter_grant_n <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("cmd_out_en_n", 1'b1, cmd_out_en_n)
    complete_run;
  end
endmodule

`default_nettype wire
